// ===== shared/srwf_defs.vh
`ifndef SRWF_DEFS_VH
`define SRWF_DEFS_VH

// ************************************************************
// Cluster numbering (octal-style values written in hex)
// ************************************************************
// Upper cluster with two shared modules, octal 44.
`define SRWF_CLN_MAX2 6'h24
// Upper cluster with one shared module, octal 22.
`define SRWF_CLN_MAX1 6'h12
// Illegal steering pointer, the all-ones value -1.
`define SRWF_CLN_ILL  6'h3f

// ************************************************************
// Command codes
// ************************************************************
// Command code c1, flagged in the fast response.
`define SRWF_CMD_C1  6'h01
// Write commands: octal 43 (port register), 45 (task register), 33 (semaphores).
`define SRWF_CMD_WSB 6'h23
`define SRWF_CMD_WST 6'h25
`define SRWF_CMD_WSM 6'h1b
// Pointer source selects.
`define SRWF_PSEL_J  2'h0
`define SRWF_PSEL_K  2'h1

// ************************************************************
// Fast response flag positions
// ************************************************************
`define SRWF_FR_VALID 0
`define SRWF_FR_ILL   2
`define SRWF_FR_C1    3
`define SRWF_FR_SP0   4

// ************************************************************
// Entry layouts and depths
// ************************************************************
// Queue entry {flag, data64, sptr6, ptr6, cmd6}; router entry adds src5.
`define SRWF_QW    83
`define SRWF_RW    88
`define SRWF_F_CMD 0
`define SRWF_F_PTR 6
`define SRWF_F_SPT 12
`define SRWF_F_DAT 18
`define SRWF_F_FLG 82
`define SRWF_QD    3
`define SRWF_IOD   2
`define SRWF_NOPT  9

`endif

// ===== rtl/srwf_rr_arb.v
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Rotating priority arbiter
// ************************************************************
// Index 0 is highest priority after reset; a winner drops to lowest.
module srwf_rr_arb #(
	parameter N  = 4,
	parameter PW = 2
) (
	input  wire         sys_clk_i,
	input  wire         reset_n_i,
	input  wire [N-1:0] req_i,
	input  wire         adv_i,
	output reg  [N-1:0] gnt_o
);
	reg [PW-1:0] top_r;
	reg [PW-1:0] win;
	integer      i;
	integer      idx;

	// Scan from lowest priority up so the highest requester wins last.
	always @*
	begin
		gnt_o = {N{1'b0}};
		win = top_r;
		idx = 0;
		for (i = N - 1; i >= 0; i = i - 1)
		begin
			idx = (top_r + i) % N;
			if (req_i[idx])
			begin
				gnt_o = {N{1'b0}};
				gnt_o[idx] = 1'b1;
				win = idx[PW-1:0];
			end
		end
	end

	// The cyclic order is kept: the one after the winner becomes highest.
	always @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			top_r <= {PW{1'b0}};
		else if (adv_i && (|req_i))
			top_r <= (win == N - 1) ? {PW{1'b0}} : win + 1'b1;
	end
endmodule // srwf_rr_arb

`default_nettype wire

// ===== rtl/srwf_top.v
`timescale 1ns/1ps
`default_nettype none
`include "srwf_defs.vh"

// Behaviour
// - Build pointer from source; forward only with sanity.
// - Command then pointer on one path, even phases.
// - Two 32-bit words fan out as bytes.
// - Cluster equals held number plus configured offset.
// - Range 1..44 or 1..22, else -1.
// - Held number inside configured range, else illegal.
// - Controls in two phases: cmd+4, sptr+2.
// - Ranks A, B, C queue; interrupts enter C.
// - Steering bit 5 sends reference to remote buffer.
// - Remote path rotates among four processors.
// - Rank M rotates among five inputs.
// - Busy fast response buffer holds rank C.
// - Fast response carries command and five flags.
// - Return command on writes and illegal reads.
// - Interrupts always win entry to rank N.
// - Source identifier has two hard-wired zero bits.
// - Router adds source bits from input path.
// - Eight bits per router, four per phase.
// - Router buffers A, B, C; interrupts use two.
// - Steering bits select holding buffer; send resume.
// - Holding buffer keeps only one reference.
// - Each output path rotates among four groups.
// - Register option resume frees its output buffer.
module srwf_top #(
	parameter [2:0] SRC_POS = 3'h0,
	parameter [1:0] GRP     = 2'h0,
	parameter [1:0] SLC     = 2'h0
) (
	input  wire                  sys_clk_i,
	input  wire                  reset_n_i,
	input  wire                  iss_vld_i,
	input  wire [5:0]            iss_cmd_i,
	input  wire [1:0]            iss_psel_i,
	input  wire [5:0]            address_reg_first_i,
	input  wire [5:0]            address_reg_second_i,
	input  wire [5:0]            instr_immediate_field_i,
	input  wire                  sanity_ok_i,
	output wire                  iss_rdy_o,
	input  wire                  dat_vld_i,
	input  wire [31:0]           dat_i,
	input  wire                  cln_load_i,
	input  wire [5:0]            cluster_number_i,
	input  wire [5:0]            cln_offset_i,
	input  wire                  two_modules_i,
	input  wire [5:0]            cln_lo_i,
	input  wire [5:0]            cln_hi_i,
	input  wire                  io_vld_i,
	input  wire [5:0]            io_cmd_i,
	output wire                  io_rdy_o,
	output reg  [5:0]            port_path_o,
	output reg                   port_path_vld_o,
	output reg  [9:0]            fan_ctl_o,
	output reg                   fan_ctl_vld_o,
	output reg  [31:0]           fan_dat_o,
	input  wire [2:0]            rem_req_i,
	input  wire                  rem_rdy_i,
	output wire [3:0]            rem_gnt_o,
	output wire                  rem_vld_o,
	output wire [`SRWF_QW-1:0]   rem_ent_o,
	input  wire [3:0]            m_req_i,
	input  wire [`SRWF_QW-1:0]   m_ext_ent_i,
	output wire [3:0]            m_gnt_o,
	input  wire                  rel_rdy_i,
	output wire                  rel_vld_o,
	output wire [5:0]            rel_cmd_o,
	output wire [4:0]            rel_flags_o,
	output reg  [3:0]            rn_nib_a_o,
	output reg  [3:0]            rn_nib_b_o,
	input  wire [3:0]            rt_vld_i,
	input  wire [4*`SRWF_RW-1:0] rt_ent_i,
	output wire [3:0]            rt_rdy_o,
	output wire [3:0]            rt_resume_o,
	input  wire [8:0]            reg_rdy_i,
	output wire [8:0]            reg_vld_o,
	output wire [9*`SRWF_RW-1:0] reg_ent_o
);
	localparam QW = `SRWF_QW;
	localparam RW = `SRWF_RW;
	localparam S_IDLE = 2'h0;
	localparam S_PTR  = 2'h1;
	localparam S_F0   = 2'h2;
	localparam S_F1   = 2'h3;

	reg  [1:0]    st_r;
	reg           ph_r;
	reg  [5:0]    cmd_r;
	reg  [5:0]    ptr_r;
	reg  [5:0]    effective_cluster_number_r;
	reg           ill_r;
	reg  [63:0]   dat_r;
	reg  [5:0]    cln_hold_r;
	reg  [1:0]    qcnt_r;
	reg  [3*QW-1:0] q_r;
	reg  [3*QW-1:0] q_nxt;
	reg           io_vld_r;
	reg  [5:0]    io_cmd_r;
	reg           rem_vld_r;
	reg  [QW-1:0] rem_r;
	reg           m_vld_r;
	reg  [QW-1:0] m_r;
	reg           n_vld_r;
	reg  [RW-1:0] n_r;
	reg           fr_vld_r;
	reg  [5:0]    fr_cmd_r;
	reg  [4:0]    fr_flg_r;
	reg  [11:0]   hclr;
	reg  [5:0]    ptr_sel;
	integer       k;
	integer       h;
	integer       f;

	wire          ev = ~ph_r;
	wire [3:0]    rg;
	wire [4:0]    mg;
	wire [3:0]    rt_rdy_w;
	wire [11:0]   hv_w;
	wire [23:0]   ho_w;
	wire [12*RW-1:0] he_w;
	wire [35:0]   og_w;

	// ************************************************************
	// Helper functions
	// ************************************************************
	// Steering bits 1..4 pick the holding buffer and its register option.
	function [3:0] steer_f;
		input [3:0] s;
		reg   [1:0] hb;
		reg   [3:0] r;
		begin
			if (s < 4'h6)
			begin
				hb = 2'h0;
				r = s;
			end
			else if (s < 4'hc)
			begin
				hb = 2'h1;
				r = s - 4'h6;
			end
			else
			begin
				hb = 2'h2;
				r = s - 4'hc;
			end
			steer_f = {hb, r[2:1]};
		end
	endfunction

	function is_wr_f;
		input [5:0] c;
		begin
			is_wr_f = (c == `SRWF_CMD_WSB) | (c == `SRWF_CMD_WST) | (c == `SRWF_CMD_WSM);
		end
	endfunction

	// ************************************************************
	// Effective cluster number
	// ************************************************************
	// Limits are octal-style; a sum of zero is the dummy cluster.
	wire [6:0] csum = {1'b0, cln_hold_r} + {1'b0, cln_offset_i};
	wire [6:0] cmax = two_modules_i ? {1'b0, `SRWF_CLN_MAX2} : {1'b0, `SRWF_CLN_MAX1};
	wire       c_ill = (csum == 7'h00) | (csum > cmax)
		| (cln_hold_r < cln_lo_i) | (cln_hold_r > cln_hi_i);
	wire [5:0] c_effective_cluster_number = c_ill ? `SRWF_CLN_ILL : csum[5:0];

	// Pointer source mux.
	always @*
	begin
		case (iss_psel_i)
			`SRWF_PSEL_J: ptr_sel = address_reg_first_i;
			`SRWF_PSEL_K: ptr_sel = address_reg_second_i;
			default:      ptr_sel = instr_immediate_field_i;
		endcase
	end

	// ************************************************************
	// Rank C head and its exits
	// ************************************************************
	wire [QW-1:0] hd = q_r[QW-1:0];
	wire hv    = (qcnt_r != 2'h0);
	wire h_ill = hd[`SRWF_F_FLG];
	wire h_rem = hd[`SRWF_F_SPT+5];
	wire fr_ret  = fr_flg_r[`SRWF_FR_VALID] & (is_wr_f(fr_cmd_r) | fr_flg_r[`SRWF_FR_ILL]);
	wire fr_busy = fr_vld_r & ~(~fr_ret | rel_rdy_i);
	wire n_adv  = n_vld_r & rt_rdy_w[GRP];
	wire n_free = ~n_vld_r | n_adv;
	wire m_free = ~m_vld_r | (n_free & ~io_vld_r);
	wire m_own  = hv & ~h_ill & ~h_rem & ~fr_busy;
	wire own_m  = m_own & mg[0] & m_free;
	wire rem_ld = hv & ~h_ill & h_rem & ~fr_busy & ~rem_vld_r;
	wire ill_go = hv & h_ill & ~fr_busy;
	wire q_pop  = own_m | rem_ld | ill_go;
	wire q_push = ev & (st_r == S_F1);
	wire [1:0] q_wi = qcnt_r - {1'b0, q_pop};
	wire [QW-1:0] q_ent = {ill_r, dat_r, effective_cluster_number_r, ptr_r, cmd_r};
	wire [4:0] src = {SRC_POS[2:1], 2'h0, SRC_POS[0]};

	assign iss_rdy_o = ev & (st_r == S_IDLE) & (qcnt_r != 2'h3);
	assign io_rdy_o  = ~io_vld_r;
	assign rt_rdy_o  = rt_rdy_w;

	// Ranks A, B, C shift toward C; a stall anywhere just holds the queue.
	always @*
	begin
		q_nxt = q_r;
		if (q_pop)
			q_nxt = q_r >> QW;
		if (q_push)
			q_nxt[q_wi*QW +: QW] = q_ent;
	end

	// ************************************************************
	// Issue, control and data fanout sequence
	// ************************************************************
	// Each step takes one even phase; odd phases leave the path idle.
	always @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_r <= S_IDLE;
			ph_r <= 1'b0;
			cmd_r <= 6'h00;
			ptr_r <= 6'h00;
			effective_cluster_number_r <= 6'h00;
			ill_r <= 1'b0;
			dat_r <= 64'h0;
			cln_hold_r <= 6'h00;
			port_path_o <= 6'h00;
			port_path_vld_o <= 1'b0;
			fan_ctl_o <= 10'h000;
			fan_ctl_vld_o <= 1'b0;
			fan_dat_o <= 32'h0;
		end
		else
		begin
			ph_r <= ~ph_r;
			port_path_vld_o <= 1'b0;
			fan_ctl_vld_o <= 1'b0;
			if (cln_load_i)
				cln_hold_r <= cluster_number_i;
			if (dat_vld_i)
				dat_r <= {dat_i, dat_r[63:32]};
			if (ev)
			begin
				case (st_r)
					S_IDLE:
					begin
						if (iss_vld_i && sanity_ok_i && qcnt_r != 2'h3)
						begin
							cmd_r <= iss_cmd_i;
							ptr_r <= ptr_sel;
							effective_cluster_number_r <= c_effective_cluster_number;
							ill_r <= c_ill;
							port_path_o <= iss_cmd_i;
							port_path_vld_o <= 1'b1;
							st_r <= S_PTR;
						end
					end
					S_PTR:
					begin
						port_path_o <= ptr_r;
						port_path_vld_o <= 1'b1;
						st_r <= S_F0;
					end
					S_F0:
					begin
						fan_ctl_o <= {ptr_r[3:0], cmd_r};
						fan_ctl_vld_o <= 1'b1;
						for (f = 0; f < 4; f = f + 1)
							fan_dat_o[8*f +: 8] <= dat_r[16*f +: 8];
						st_r <= S_F1;
					end
					S_F1:
					begin
						fan_ctl_o <= {2'h0, ptr_r[5:4], effective_cluster_number_r};
						fan_ctl_vld_o <= 1'b1;
						for (f = 0; f < 4; f = f + 1)
							fan_dat_o[8*f +: 8] <= dat_r[16*f+8 +: 8];
						st_r <= S_IDLE;
					end
					default: st_r <= S_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// Ranks C, remote buffer, M, N and fast response
	// ************************************************************
	// Order: own processor, then 0, 11, 1 on the remote path.
	srwf_rr_arb #(.N(4), .PW(2)) u_rem_arb (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.req_i     ({rem_req_i, rem_vld_r}),
		.adv_i     (rem_rdy_i),
		.gnt_o     (rg)
	);

	// Order: own, 0, 11, 1, remote input.
	srwf_rr_arb #(.N(5), .PW(3)) u_m_arb (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.req_i     ({m_req_i, m_own}),
		.adv_i     (m_free),
		.gnt_o     (mg)
	);

	assign rem_gnt_o   = rg & {4{rem_rdy_i}};
	assign rem_vld_o   = rem_vld_r & rg[0];
	assign rem_ent_o   = rem_r;
	assign m_gnt_o     = mg[4:1] & {4{m_free}};
	assign rel_vld_o   = fr_vld_r & fr_ret;
	assign rel_cmd_o   = fr_cmd_r;
	assign rel_flags_o = fr_flg_r;

	// Illegal references retire from rank C with only a fast response.
	always @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			qcnt_r <= 2'h0;
			q_r <= {3*QW{1'b0}};
			io_vld_r <= 1'b0;
			io_cmd_r <= 6'h00;
			rem_vld_r <= 1'b0;
			rem_r <= {QW{1'b0}};
			m_vld_r <= 1'b0;
			m_r <= {QW{1'b0}};
			n_vld_r <= 1'b0;
			n_r <= {RW{1'b0}};
			fr_vld_r <= 1'b0;
			fr_cmd_r <= 6'h00;
			fr_flg_r <= 5'h00;
			rn_nib_a_o <= 4'h0;
			rn_nib_b_o <= 4'h0;
		end
		else
		begin
			qcnt_r <= qcnt_r + {1'b0, q_push} - {1'b0, q_pop};
			q_r <= q_nxt;
			// Interrupts skip ranks A and B.
			if (io_vld_i && !io_vld_r)
			begin
				io_vld_r <= 1'b1;
				io_cmd_r <= io_cmd_i;
			end
			else if (n_free)
				io_vld_r <= 1'b0;
			if (rem_ld)
			begin
				rem_vld_r <= 1'b1;
				rem_r <= hd;
			end
			else if (rg[0] && rem_rdy_i)
				rem_vld_r <= 1'b0;
			if (m_free)
			begin
				m_vld_r <= |{m_req_i, m_own};
				m_r <= mg[0] ? hd : m_ext_ent_i;
			end
			// An interrupt waiting in rank C always takes rank N first.
			if (n_free)
			begin
				n_vld_r <= io_vld_r | m_vld_r;
				if (io_vld_r)
					n_r <= {src, 1'b1, 64'h0, 12'h000, io_cmd_r};
				else
					n_r <= {src, m_r};
			end
			// A new load wins over the release of the previous response.
			if (q_pop)
			begin
				fr_vld_r <= 1'b1;
				fr_cmd_r <= hd[5:0];
				fr_flg_r <= {hd[`SRWF_F_SPT], hd[5:0] == `SRWF_CMD_C1, h_ill, 1'b0, 1'b1};
			end
			else if (fr_vld_r && (!fr_ret || rel_rdy_i))
				fr_vld_r <= 1'b0;
			// Own 16-bit slice: 8 bits per router path, low nibble first.
			rn_nib_a_o <= n_r[`SRWF_F_DAT + SLC*16 + ph_r*4 +: 4];
			rn_nib_b_o <= n_r[`SRWF_F_DAT + SLC*16 + 8 + ph_r*4 +: 4];
		end
	end

	// ************************************************************
	// Router option: group buffers and holding buffers
	// ************************************************************
	genvar g;
	genvar j;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_grp
			localparam [31:0] GI = g;
			wire [1:0]    gid = GI[1:0];
			wire          in_v = (g == GRP) ? n_vld_r : rt_vld_i[g];
			wire [RW-1:0] in_r = (g == GRP) ? n_r : rt_ent_i[g*RW +: RW];
			wire [RW-1:0] in_e = {in_r[87:86], gid, in_r[83:0]};
			reg  [1:0]    c_r;
			reg  [3*RW-1:0] b_r;
			reg  [3*RW-1:0] b_nxt;
			reg  [2:0]    hv_r;
			reg  [3*RW-1:0] he_r;
			reg  [5:0]    ho_r;
			reg           res_r;
			integer       hh;
			wire [RW-1:0] head = b_r[RW-1:0];
			wire [3:0]    sel = steer_f(head[`SRWF_F_SPT+4:`SRWF_F_SPT+1]);
			// Interrupt references may use only two buffers.
			wire lim  = in_e[`SRWF_F_FLG] ? (c_r < `SRWF_IOD) : (c_r < `SRWF_QD);
			wire push = in_v & lim;
			wire pop  = (c_r != 2'h0) & ~hv_r[sel[3:2]];
			wire [1:0] wi = c_r - {1'b0, pop};

			assign rt_rdy_w[g]       = lim;
			assign rt_resume_o[g]    = res_r;
			assign hv_w[g*3 +: 3]    = hv_r;
			assign ho_w[g*6 +: 6]    = ho_r;
			assign he_w[g*3*RW +: 3*RW] = he_r;

			// Buffer A drains first and B, C move up behind it.
			always @*
			begin
				b_nxt = b_r;
				if (pop)
					b_nxt = b_r >> RW;
				if (push)
					b_nxt[wi*RW +: RW] = in_e;
			end

			always @(posedge sys_clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					c_r <= 2'h0;
					b_r <= {3*RW{1'b0}};
					hv_r <= 3'h0;
					he_r <= {3*RW{1'b0}};
					ho_r <= 6'h00;
					res_r <= 1'b0;
				end
				else
				begin
					c_r <= c_r + {1'b0, push} - {1'b0, pop};
					b_r <= b_nxt;
					res_r <= pop;
					for (hh = 0; hh < 3; hh = hh + 1)
					begin
						if (pop && sel[3:2] == hh)
						begin
							hv_r[hh] <= 1'b1;
							he_r[hh*RW +: RW] <= head;
							ho_r[hh*2 +: 2] <= sel[1:0];
						end
						else if (hclr[g*3+hh])
							hv_r[hh] <= 1'b0;
					end
				end
			end
		end

		// ************************************************************
		// Output paths to the register options
		// ************************************************************
		for (j = 0; j < `SRWF_NOPT; j = j + 1)
		begin : g_out
			reg  [3:0]    rq;
			reg  [RW-1:0] pick;
			reg           ov_r;
			reg  [RW-1:0] oe_r;
			integer       kk;
			wire [3:0]    gn;
			wire          fr = ~ov_r | reg_rdy_i[j];

			// A group asks when its holding buffer targets this option.
			always @*
			begin
				pick = {RW{1'b0}};
				for (kk = 0; kk < 4; kk = kk + 1)
				begin
					rq[kk] = hv_w[kk*3 + j/3] & (ho_w[(kk*3 + j/3)*2 +: 2] == j % 3);
					if (gn[kk])
						pick = he_w[(kk*3 + j/3)*RW +: RW];
				end
			end

			// Independent priority per path, group 0 first.
			srwf_rr_arb #(.N(4), .PW(2)) u_arb (
				.sys_clk_i (sys_clk_i),
				.reset_n_i (reset_n_i),
				.req_i     (rq),
				.adv_i     (fr),
				.gnt_o     (gn)
			);

			assign og_w[j*4 +: 4]       = gn & {4{fr}};
			assign reg_vld_o[j]         = ov_r;
			assign reg_ent_o[j*RW +: RW] = oe_r;

			always @(posedge sys_clk_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					ov_r <= 1'b0;
					oe_r <= {RW{1'b0}};
				end
				else if (fr)
				begin
					ov_r <= |rq;
					oe_r <= pick;
				end
			end
		end
	endgenerate

	// A grant on any of the three paths of a holding buffer empties it.
	always @*
	begin
		for (k = 0; k < 4; k = k + 1)
			for (h = 0; h < 3; h = h + 1)
				hclr[k*3+h] = og_w[(h*3)*4+k] | og_w[(h*3+1)*4+k] | og_w[(h*3+2)*4+k];
	end
endmodule // srwf_top

`default_nettype wire

// ===== testbench/srwf_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Issue, fanout and release port checker
// ****************************************
module srwf_chk (
	input wire logic       sys_clk_i,
	input wire logic       reset_n_i,
	input wire logic       iss_vld_i,
	input wire logic [5:0] iss_cmd_i,
	input wire logic [1:0] iss_psel_i,
	input wire logic [5:0] address_reg_first_i,
	input wire logic [5:0] address_reg_second_i,
	input wire logic [5:0] instr_immediate_field_i,
	input wire logic       sanity_ok_i,
	input wire logic       iss_rdy_o,
	input wire logic [5:0] port_path_o,
	input wire logic       port_path_vld_o,
	input wire logic [9:0] fan_ctl_o,
	input wire logic       fan_ctl_vld_o,
	input wire logic       rel_rdy_i,
	input wire logic       rel_vld_o,
	input wire logic [5:0] rel_cmd_o,
	input wire logic [4:0] rel_flags_o
);
	// Selected pointer source; the others carry decoys in the bench.
	wire [5:0] ptr    = (iss_psel_i == 2'h0) ? address_reg_first_i :
		(iss_psel_i == 2'h1) ? address_reg_second_i : instr_immediate_field_i;
	wire [3:0] ptr_lo = ptr[3:0];
	wire [1:0] ptr_hi = ptr[5:4];
	wire       take   = iss_vld_i & iss_rdy_o & sanity_ok_i;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	AST_CMD: assert property (take |=> port_path_vld_o && port_path_o == $past(iss_cmd_i))
		else $error("command word wrong");
	AST_PTR: assert property (take |-> ##3 port_path_vld_o && port_path_o == $past(ptr, 3))
		else $error("pointer word wrong");
	AST_NOSAN: assert property (iss_vld_i && iss_rdy_o && !sanity_ok_i |-> ##1 !port_path_vld_o [*3])
		else $error("command forwarded without sanity");
	AST_FAN1: assert property (take |-> ##5 fan_ctl_vld_o &&
		fan_ctl_o == {$past(ptr_lo, 5), $past(iss_cmd_i, 5)})
		else $error("first control phase wrong");
	AST_FAN2: assert property (take |-> ##7 fan_ctl_vld_o && fan_ctl_o[9:6] == {2'b00, $past(ptr_hi, 7)})
		else $error("second control phase wrong");
	AST_PHASE: assert property (iss_rdy_o |=> !iss_rdy_o)
		else $error("ready on an odd phase");
	AST_REL_HOLD: assert property (rel_vld_o && !rel_rdy_i |=>
		rel_vld_o && $stable(rel_cmd_o) && $stable(rel_flags_o))
		else $error("fast response dropped early");
	AST_REL_FLG: assert property (rel_vld_o |-> rel_flags_o[0] &&
		(rel_flags_o[3] == (rel_cmd_o == 6'h01)) && (!rel_flags_o[2] || rel_flags_o[4]))
		else $error("fast response flags wrong");
endmodule // srwf_chk

bind srwf_top srwf_chk i_srwf_chk (.*);

`default_nettype wire

// ===== testbench/srwf_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Issuing processor: command, data words, release
// ****************************************
module srwf_cpu_model (
	input  wire logic        sys_clk_i,
	input  wire logic        iss_rdy_i,
	input  wire logic        rel_vld_i,
	output logic             iss_vld_o,
	output logic [5:0]       iss_cmd_o,
	output logic [1:0]       iss_psel_o,
	output logic [5:0]       first_o,
	output logic [5:0]       second_o,
	output logic [5:0]       imm_o,
	output logic             sanity_o,
	output logic             dat_vld_o,
	output logic [31:0]      dat_o,
	output logic             rel_rdy_o
);
	int hold_cnt;

	// Idle levels at time zero.
	initial
	begin
		hold_cnt = 0;
		iss_vld_o = 1'b0;
		iss_cmd_o = 6'h00;
		iss_psel_o = 2'h0;
		first_o = 6'h00;
		second_o = 6'h00;
		imm_o = 6'h00;
		sanity_o = 1'b0;
		dat_vld_o = 1'b0;
		dat_o = 32'h0000_0000;
		rel_rdy_o = 1'b0;
	end

	// Offer a command until taken, then send the two words, lower first.
	task automatic issue(input logic [5:0] cmd, input logic [1:0] psel,
		input logic [5:0] ptr, input logic san, input logic [63:0] d);
		int n;
		iss_cmd_o = cmd;
		iss_psel_o = psel;
		first_o = (psel == 2'h0) ? ptr : ~ptr;
		second_o = (psel == 2'h1) ? ptr : ~ptr;
		imm_o = psel[1] ? ptr : ~ptr;
		sanity_o = san;
		iss_vld_o = 1'b1;
		n = 0;
		while (iss_rdy_i !== 1'b1 && n < 16)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		@(negedge sys_clk_i);
		iss_vld_o = 1'b0;
		iss_cmd_o = ~cmd;
		dat_vld_o = 1'b1;
		dat_o = d[31:0];
		@(negedge sys_clk_i);
		dat_o = d[63:32];
		@(negedge sys_clk_i);
		dat_vld_o = 1'b0;
		dat_o = ~dat_o;
	endtask

	// Withholding the release a while proves the response stands.
	always @(negedge sys_clk_i)
	begin
		rel_rdy_o = rel_vld_i && hold_cnt == 0;
		if (rel_vld_i && hold_cnt > 0)
			hold_cnt--;
	end
endmodule // srwf_cpu_model

`default_nettype wire

// ===== testbench/tb_srwf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "srwf_defs.vh"

`define SRWF_CHK(nm, exp, got) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
		end \
	end

// ****************************************
// Forward path bench
// ****************************************
module tb_srwf_top;
	logic                  sys_clk_i, reset_n_i, iss_vld_i, sanity_ok_i, iss_rdy_o, dat_vld_i;
	logic                  cln_load_i, two_modules_i, io_vld_i, io_rdy_o, port_path_vld_o;
	logic                  fan_ctl_vld_o, rem_rdy_i, rem_vld_o, rel_rdy_i, rel_vld_o;
	logic [5:0]            iss_cmd_i, address_reg_first_i, address_reg_second_i, io_cmd_i;
	logic [5:0]            instr_immediate_field_i, cluster_number_i, cln_offset_i;
	logic [5:0]            cln_lo_i, cln_hi_i, port_path_o, rel_cmd_o;
	logic [1:0]            iss_psel_i;
	logic [31:0]           dat_i, fan_dat_o;
	logic [9:0]            fan_ctl_o;
	logic [2:0]            rem_req_i;
	logic [3:0]            rem_gnt_o, m_req_i, m_gnt_o, rn_nib_a_o, rn_nib_b_o;
	logic [3:0]            rt_vld_i, rt_rdy_o, rt_resume_o;
	logic [4:0]            rel_flags_o;
	logic [`SRWF_QW-1:0]   rem_ent_o, m_ext_ent_i;
	logic [4*`SRWF_RW-1:0] rt_ent_i;
	logic [8:0]            reg_rdy_i, reg_vld_o;
	logic [9*`SRWF_RW-1:0] reg_ent_o;
	int                    num_errors, n_checks, n;
	// {cluster, offset, {output path, two modules}, command, pointer select, pointer, cluster}.
	logic [55:0]           tbl [8] = '{56'h03_02_11_23_00_2a_05, 56'h20_04_01_25_01_15_24,
		56'h20_05_01_1b_02_3c_3f, 56'h10_02_40_23_03_07_12, 56'h10_03_00_25_00_31_3f,
		56'h00_00_01_01_01_0e_3f, 56'h21_00_01_1b_02_22_3f, 56'h00_05_01_23_00_19_3f};

	srwf_top i_srwf_top (.*);
	srwf_cpu_model i_srwf_cpu_model (.sys_clk_i(sys_clk_i), .iss_rdy_i(iss_rdy_o),
		.rel_vld_i(rel_vld_o), .iss_vld_o(iss_vld_i), .iss_cmd_o(iss_cmd_i),
		.iss_psel_o(iss_psel_i), .first_o(address_reg_first_i), .second_o(address_reg_second_i),
		.imm_o(instr_immediate_field_i), .sanity_o(sanity_ok_i), .dat_vld_o(dat_vld_i),
		.dat_o(dat_i), .rel_rdy_o(rel_rdy_i));

	// Clock at 4 ns.
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the run needs.
	initial
	begin
		#20000;
		num_errors++;
		give_verdict;
	end

	// One command through the forward path; the remote case stalls its path first.
	task automatic run_case(input logic [55:0] e);
		logic [5:0] cmd, ptr, ex;
		logic       remote;
		cmd = e[29:24];
		ptr = e[13:8];
		ex = e[5:0];
		remote = ex[5] && ex != `SRWF_CLN_ILL;
		cluster_number_i = e[53:48];
		cln_offset_i = e[45:40];
		two_modules_i = e[32];
		cln_load_i = 1'b1;
		rem_rdy_i = !remote;
		rem_req_i = remote ? 3'h7 : 3'h0;
		@(negedge sys_clk_i);
		cln_load_i = 1'b0;
		i_srwf_cpu_model.hold_cnt = 6;
		i_srwf_cpu_model.issue(cmd, e[17:16], ptr, 1'b1, 64'h8877665544332211);
		`SRWF_CHK("pointer", {1'b1, ptr}, {port_path_vld_o, port_path_o})
		repeat (2) @(negedge sys_clk_i);
		`SRWF_CHK("ctl1", {1'b1, ptr[3:0], cmd}, {fan_ctl_vld_o, fan_ctl_o})
		`SRWF_CHK("dat1", 32'h77553311, fan_dat_o)
		repeat (2) @(negedge sys_clk_i);
		`SRWF_CHK("ctl2", {3'h4, ptr[5:4], ex}, {fan_ctl_vld_o, fan_ctl_o})
		`SRWF_CHK("dat2", 32'h88664422, fan_dat_o)
		if (remote)
		begin
			n = 0;
			while (rem_vld_o !== 1'b1 && n < 40)
			begin
				@(negedge sys_clk_i);
				n++;
			end
			`SRWF_CHK("rem cluster", ex, rem_ent_o[17:12])
			repeat (3) @(negedge sys_clk_i);
			`SRWF_CHK("rem hold", 1'b1, rem_vld_o)
			// Grants show only while the path is free.
			rem_rdy_i = 1'b1;
			#1;
			`SRWF_CHK("rem grant", 4'h1, rem_gnt_o)
			@(negedge sys_clk_i);
			`SRWF_CHK("rem next", 4'h2, rem_gnt_o)
			rem_req_i = 3'h0;
		end
		n = 0;
		while (rel_vld_o !== 1'b1 && n < 60)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		`SRWF_CHK("rel cmd", cmd, rel_cmd_o)
		`SRWF_CHK("rel flags", {ex[0], cmd == 6'h01, ex == 6'h3f, 1'b1},
			{rel_flags_o[4:2], rel_flags_o[0]})
		n = 0;
		while (rel_vld_o === 1'b1 && n < 20)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		// Local writes wait at their output path until the register option resumes.
		if (!remote && ex != `SRWF_CLN_ILL)
		begin
			`SRWF_CHK("reg vld", 9'h001 << e[39:36], reg_vld_o)
			`SRWF_CHK("reg sptr", ex, reg_ent_o[e[39:36]*`SRWF_RW+`SRWF_F_SPT +: 6])
			reg_rdy_i = 9'h1ff;
			@(negedge sys_clk_i);
			reg_rdy_i = 9'h000;
		end
	endtask

	// Main sequence: every cluster case, then a command without sanity and an interrupt.
	initial
	begin
		reset_n_i = 1'b0;
		cln_load_i = 1'b0;
		cluster_number_i = 6'h00;
		cln_offset_i = 6'h00;
		two_modules_i = 1'b1;
		cln_lo_i = 6'h01;
		cln_hi_i = 6'h20;
		io_vld_i = 1'b0;
		io_cmd_i = 6'h00;
		rem_req_i = 3'h0;
		rem_rdy_i = 1'b1;
		m_req_i = 4'h0;
		m_ext_ent_i = '0;
		rt_vld_i = 4'h0;
		rt_ent_i = '0;
		reg_rdy_i = 9'h000;
		num_errors = 0;
		n_checks = 0;
		repeat (5) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		foreach (tbl[i])
			run_case(tbl[i]);
		i_srwf_cpu_model.issue(6'h23, 2'h0, 6'h11, 1'b0, 64'h0);
		n = 0;
		repeat (8)
		begin
			@(negedge sys_clk_i);
			if (port_path_vld_o !== 1'b0)
				n++;
		end
		`SRWF_CHK("no sanity", 0, n)
		// Own wins left processor 0 ahead of processor 11.
		m_req_i = 4'h3;
		#1;
		`SRWF_CHK("m grant", 4'h1, m_gnt_o)
		m_req_i = 4'h0;
		io_vld_i = 1'b1;
		io_cmd_i = 6'h07;
		n = 0;
		while (io_rdy_o !== 1'b1 && n < 20)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		@(negedge sys_clk_i);
		io_vld_i = 1'b0;
		`SRWF_CHK("io taken", 1'b1, n < 20)
		repeat (20) @(negedge sys_clk_i);
		`SRWF_CHK("io out", {9'h001, 7'h47}, {reg_vld_o, reg_ent_o[82], reg_ent_o[5:0]})
		give_verdict;
	end
endmodule // tb_srwf_top

`default_nettype wire
